/* core/ictr_target_regs.v */
// Decided for this implementation: the AHB-Lite interface to the registers.
`include "ictr_map.vh"
`timescale 1ns/100ps
`default_nettype none

module ictr_target_regs
(
	input  wire        mclk,
	input  wire        reset_n,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	input  wire [11:0] irq_in,
	output reg  [11:0] irq_core0,
	output reg  [11:0] irq_core1
);

	// ============================================================
	// Register indices.
	localparam [1:0] IDX_T36_39 = 2'h0;
	localparam [1:0] IDX_T40_43 = 2'h1;
	localparam [1:0] IDX_T44_47 = 2'h2;
	localparam [1:0] IDX_NONE   = 2'h3;

	// ============================================================
	// Address phase decode.
	wire [`ICTR_OFS_W-1:0] ofs;
	wire                   xfer_ok;
	wire                   size_ok;
	wire                   wr_req;
	wire                   rd_req;
	reg                    hit;
	reg  [1:0]             idx;

	assign ofs     = haddr[`ICTR_OFS_W-1:0];
	assign xfer_ok = hsel & hready & (htrans == `ICTR_HTRANS_NSEQ);
	assign size_ok = (hsize == `ICTR_HSIZE_WORD);
	assign wr_req  = xfer_ok & hwrite & hit & size_ok;
	assign rd_req  = xfer_ok & ~hwrite;

	always @*
	begin
		hit = 1'h1;
		idx = IDX_NONE;
		case (ofs)
			`ICTR_OFS_T36_39:
			begin
				idx = IDX_T36_39;
			end
			`ICTR_OFS_T40_43:
			begin
				idx = IDX_T40_43;
			end
			`ICTR_OFS_T44_47:
			begin
				idx = IDX_T44_47;
			end
			default:
			begin
				hit = 1'h0;
				idx = IDX_NONE;
			end
		endcase
	end

	// The slave never stretches a transfer and never reports an error.
	assign hreadyout = 1'h1;
	assign hresp     = `ICTR_HRESP_OKAY;

	// ============================================================
	// Write data phase.
	// Writes to unmapped addresses or with a sub-word hsize are dropped silently, so a
	// byte store can never leave a field half written.
	reg         wr_pend_q;
	reg  [1:0]  wr_idx_q;
	wire [31:0] wr_data;

	assign wr_data = hwdata & `ICTR_FIELD_MASK;

	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_pend_q <= 1'h0;
			wr_idx_q  <= IDX_NONE;
		end
		else
		begin
			wr_pend_q <= wr_req;
			wr_idx_q  <= idx;
		end
	end

	// ============================================================
	// Target storage, one word per register.
	wire [`ICTR_NUM_REGS-1:0]             wr_en;
	wire [`ICTR_REG_W*`ICTR_NUM_REGS-1:0] tgt_flat;

	genvar r;
	generate
		for (r = 0; r < `ICTR_NUM_REGS; r = r + 1)
		begin : g_reg
			reg [`ICTR_REG_W-1:0] word_q;

			assign wr_en[r] = wr_pend_q & ({30'h00000000, wr_idx_q} == r);

			always @(posedge mclk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					word_q <= `ICTR_RESET_VAL;
				end
				else if (wr_en[r])
				begin
					word_q <= wr_data;
				end
			end

			assign tgt_flat[r*`ICTR_REG_W +: `ICTR_REG_W] = word_q;
		end
	endgenerate

	// ============================================================
	// Read path.
	// A read right after a write to the same word sees the new value through the
	// forwarded wr_data, since the write lands only at the end of its data phase.
	reg [31:0] rd_word;

	always @*
	begin
		rd_word = 32'h00000000;
		case (idx)
			IDX_T36_39:
			begin
				rd_word = tgt_flat[31:0];
			end
			IDX_T40_43:
			begin
				rd_word = tgt_flat[63:32];
			end
			IDX_T44_47:
			begin
				rd_word = tgt_flat[95:64];
			end
			default:
			begin
				rd_word = 32'h00000000;
			end
		endcase
		if (wr_pend_q && hit && (wr_idx_q == idx))
		begin
			rd_word = wr_data;
		end
	end

	// Read data is registered at the address phase, so it stands in the data phase.
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hrdata <= 32'h00000000;
		end
		else if (rd_req)
		begin
			hrdata <= rd_word;
		end
	end

	// ============================================================
	// Routing of each interrupt to its selected cores.
	wire [`ICTR_NUM_IRQ-1:0] core0_d;
	wire [`ICTR_NUM_IRQ-1:0] core1_d;

	genvar g;
	generate
		for (g = 0; g < `ICTR_NUM_IRQ; g = g + 1)
		begin : g_route
			wire [1:0] fld;
			reg        sel0;
			reg        sel1;

			assign fld = tgt_flat[(g / `ICTR_FLD_PER_REG) * `ICTR_REG_W
				+ (g % `ICTR_FLD_PER_REG) * `ICTR_LANE_W +: `ICTR_FIELD_W];

			always @*
			begin
				sel0 = 1'h0;
				sel1 = 1'h0;
				case (fld)
					`ICTR_TGT_NONE:
					begin
						sel0 = 1'h0;
						sel1 = 1'h0;
					end
					`ICTR_TGT_CORE0:
					begin
						sel0 = 1'h1;
						sel1 = 1'h0;
					end
					`ICTR_TGT_CORE1:
					begin
						sel0 = 1'h0;
						sel1 = 1'h1;
					end
					`ICTR_TGT_BOTH:
					begin
						sel0 = 1'h1;
						sel1 = 1'h1;
					end
					default:
					begin
						sel0 = 1'h0;
						sel1 = 1'h0;
					end
				endcase
			end

			assign core0_d[g] = irq_in[g] & sel0;
			assign core1_d[g] = irq_in[g] & sel1;
		end
	endgenerate

	// Registered outputs keep the routed levels glitch free toward the cores.
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_core0 <= 12'h000;
			irq_core1 <= 12'h000;
		end
		else
		begin
			irq_core0 <= core0_d;
			irq_core1 <= core1_d;
		end
	end

endmodule // ictr_target_regs

`default_nettype wire

/* core/ictr_map.vh */
`ifndef ICTR_MAP_VH
`define ICTR_MAP_VH
// ============================================================
// Register offsets, relative to the distributor base.
`define ICTR_OFS_T36_39 16'h1824
`define ICTR_OFS_T40_43 16'h1828
`define ICTR_OFS_T44_47 16'h182C
`define ICTR_OFS_W      16
// ============================================================
// Field layout: four 2-bit fields, one per byte lane.
`define ICTR_FIELD_W    2
`define ICTR_LANE_W     8
`define ICTR_REG_W      32
`define ICTR_FLD_PER_REG 4
`define ICTR_NUM_REGS   3
`define ICTR_NUM_IRQ    12
`define ICTR_FIRST_IRQ  36
`define ICTR_RESET_VAL  32'h00000000
`define ICTR_FIELD_MASK 32'h03030303
// ============================================================
// Target field encodings.
`define ICTR_TGT_NONE   2'h0
`define ICTR_TGT_CORE0  2'h1
`define ICTR_TGT_CORE1  2'h2
`define ICTR_TGT_BOTH   2'h3
// ============================================================
// AHB-Lite encodings.
`define ICTR_HTRANS_NSEQ 2'h2
`define ICTR_HSIZE_WORD  3'h2
`define ICTR_HRESP_OKAY  1'h0
`endif

/* dv/ictr_props.sv */
`timescale 1ns/100ps
`default_nettype none
module ictr_props(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [11:0] irq_in,
	input wire logic [11:0] irq_core0,
	input wire logic [11:0] irq_core1);
default clocking @(posedge mclk); endclocking
default disable iff (!reset_n);
AST_RDY: assert property (hreadyout) else $error("wait state");
AST_OK: assert property (!hresp) else $error("bad response");
AST_RST: assert property ($rose(reset_n) |-> !irq_core0 && !irq_core1) else $error("rst");
AST_RD0: assert property (!(hrdata & 32'hFCFCFCFC)) else $error("unused bits set");
AST_C0: assert property (!(irq_core0 & ~$past(irq_in))) else $error("core0 spurious");
AST_C1: assert property (!(irq_core1 & ~$past(irq_in))) else $error("core1 spurious");
AST_Q: assert property (!irq_in |=> !irq_core0 && !irq_core1) else $error("quiet");
AST_DROP: assert property ($fell(irq_in[0]) |-> ##1 !irq_core0[0]) else $error("drop");
cover property (irq_core0 & irq_core1);
cover property (hrdata == 32'h03030303);
cover property (irq_core1 & ~irq_core0);
cover property ($fell(irq_in[0]) ##1 !irq_core0[0]);
endmodule // ictr_props
`default_nettype wire

/* dv/ictr_cores.sv */
`timescale 1ns/100ps
`default_nettype none
module ictr_cores(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [11:0] irq_core0,
	input wire logic [11:0] irq_core1,
	output logic [11:0] seen0,
	output logic [11:0] seen1);
// Each core latches every line it saw since the last reset, so short pulses are not lost.
always @(posedge mclk or negedge reset_n)
	if (!reset_n) {seen1, seen0} <= 24'h0;
	else {seen1, seen0} <= {seen1 | irq_core1, seen0 | irq_core0};
endmodule // ictr_cores
`default_nettype wire

/* dv/ictr_target_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module ictr_target_regs_tb;
logic mclk = 0, reset_n = 0, hsel = 0, hwrite = 0;
logic [31:0] haddr = 0, hwdata = 0, r;
logic [1:0] htrans = 0;
logic [2:0] hsize = 3'h2;
logic [11:0] irq_in = 0, s0, s1, e0, e1;
wire logic hreadyout, hresp;
wire logic [31:0] hrdata;
wire logic [11:0] irq_core0, irq_core1;
int fail_count = 0, checks_done = 0;
logic [31:0] rows [3][3] = '{'{32'h1824, 32'hFC02FD01, 32'h00020101},
	'{32'h1828, 32'hFFFFFFFF, 32'h03030303}, '{32'h182C, 32'h01020300, 32'h01020300}};
ictr_target_regs DUT(.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
	.hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq_in, .irq_core0, .irq_core1);
ictr_cores CORES(.mclk, .reset_n, .irq_core0, .irq_core1, .seen0(s0), .seen1(s1));
initial forever #10 mclk = ~mclk;
task cmp(input logic [31:0] got, exp);
	checks_done++;
	if (got !== exp)
	begin
		fail_count++;
		$display("wrong value at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task bus(input logic w, input logic [31:0] a, d);
	hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
	do @(posedge mclk); while (hreadyout !== 1'b1);
	hsel <= 0; htrans <= 0; hwdata <= d;
	do @(posedge mclk); while (hreadyout !== 1'b1);
	r = hrdata;
endtask
task finish_test;
	$display("checks %0d mismatches %0d", checks_done, fail_count);
	if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
	else $display("*** FAIL ***");
	$finish;
endtask
initial begin #100000; fail_count++; finish_test; end
initial
begin
	irq_in <= 12'hFFF;
	repeat (16) @(posedge mclk);
	reset_n <= 1;
	@(posedge mclk);
	bus(0, 32'h1824, 0);
	cmp(r, 0);
	cmp({irq_core1, irq_core0}, 0);
	$display("reset test done");
	foreach (rows[i]) bus(1, rows[i][0], rows[i][1]);
	bus(1, 32'h1830, 32'hFFFFFFFF);
	bus(0, 32'h1830, 0);
	cmp(r, 0);
	hsize <= 3'h0;
	bus(1, 32'h1824, 32'h03030303);
	hsize <= 3'h2;
	foreach (rows[i]) begin bus(0, rows[i][0], 0); cmp(r, rows[i][2]); end
	$display("register rows test done");
	for (int k = 0; k < 12; k++) {e1[k], e0[k]} = rows[k / 4][2][8 * (k % 4) +: 2];
	repeat (2) @(posedge mclk);
	cmp({irq_core1, irq_core0}, {e1, e0});
	cmp({s1, s0}, {e1, e0});
	irq_in <= 12'h000;
	repeat (2) @(posedge mclk);
	cmp({irq_core1, irq_core0}, 0);
	$display("routing test done");
	reset_n <= 0;
	@(posedge mclk);
	reset_n <= 1;
	irq_in <= 12'hFFF;
	repeat (2) @(posedge mclk);
	cmp({irq_core1, irq_core0}, 0);
	foreach (rows[i]) begin bus(0, rows[i][0], 0); cmp(r, 0); end
	$display("mid-run reset test done");
	finish_test;
end
endmodule // ictr_target_regs_tb
bind ictr_target_regs ictr_props PROPS(.mclk, .reset_n, .hreadyout, .hresp, .hrdata,
	.irq_in, .irq_core0, .irq_core1);
`default_nettype wire
